// ### swhp_params.svh
/*
  Constants for the hot plug, loss-of-signal and EDID control register bank:
  register offsets, field positions, reset values and timing figures.
  Assumes it is included by bare name into the bank's package or module.
*/
`ifndef SWHP_PARAMS_SVH
`define SWHP_PARAMS_SVH

// Register offsets on the control port.
`define SWHP_OFS_PULSE_WIDTH   8'h05
`define SWHP_OFS_HP_OVERRIDE   8'h06
`define SWHP_OFS_LOSS_CTRL     8'h07
`define SWHP_OFS_REPL_MODE     8'h0e
`define SWHP_OFS_WRITE_KEY     8'h0f
`define SWHP_OFS_LOSS_STATUS   8'h10
`define SWHP_OFS_SILICON_STEP  8'hfe
`define SWHP_OFS_PART_CODE     8'hff

// Field positions.
`define SWHP_BIT_MANUAL_SEL    4
`define SWHP_BIT_LOSS_EN       0
`define SWHP_BIT_SQUELCH_EN    2
`define SWHP_BIT_THR_LO        4
`define SWHP_BIT_THR_HI        5
`define SWHP_BIT_REPL_BYPASS   0

// Reset values.
`define SWHP_RST_PULSE_WIDTH   8'h05
`define SWHP_RST_HP_OVERRIDE   8'h00
`define SWHP_RST_LOSS_CTRL     8'h00
`define SWHP_RST_REPL_MODE     8'h00
`define SWHP_RST_WRITE_KEY     8'h00
`define SWHP_RST_READ_DATA     8'h00

// Key that opens the EDID memory for writing.
`define SWHP_UNLOCK_KEY        8'h96

// Hot plug pulse step in ms and the clock rate in MHz.
`define SWHP_STEP_MS           24
`define SWHP_CLK_MHZ           125
`define SWHP_STEP_CYCLES       (`SWHP_STEP_MS * 1000 * `SWHP_CLK_MHZ)

`endif

// ### swhp_pkg.sv
/*
  Types for the hot plug, loss-of-signal and EDID control register bank.
  Assumes the constants header is compiled alongside.
*/
package swhp_pkg;

  // State of the automatic hot plug pulse generator.
  typedef enum logic {
    SWHP_HP_IDLE,
    SWHP_HP_LOW
  } swhp_hp_state_t;

endpackage

// ### swhp_regs.sv
/*
  Upper control and status register bank of a four-input link switch:
  hot plug override and automatic pulse, loss-of-signal control and status,
  EDID replicator mode, EDID write-protect key, identification codes.
  Assumes the serial control port engine outside runs on mclk and hands over
  one-cycle read and write strobes with an 8-bit address and data, and that
  the analog clock-activity detectors drive asynchronous levels.
*/
`timescale 1ns/10ps
`include "swhp_params.svh"

module swhp_regs
  import swhp_pkg::*;
#(
  parameter int          STEP_CYCLES  = `SWHP_STEP_CYCLES,
  parameter int          STEP_W       = 22,
  // Identification values are arbitrary.
  parameter logic [7:0]  SILICON_STEP = 8'h5a,
  parameter logic [7:0]  PART_CODE    = 8'h11
) (
  // Clock and reset.
  input  wire logic       mclk,
  input  wire logic       arst_n,
  // Register port from the serial control engine.
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  output logic            reg_rvalid,
  // Channel switch event and newly selected input.
  input  wire logic       chan_switch,
  input  wire logic [1:0] chan_sel,
  // Hot plug open-drain outputs, bit 0 is input A.
  output logic      [3:0] hot_plug_out,
  output logic      [3:0] hot_plug_oe_n,
  // Clock activity from the analog detectors, asynchronous.
  input  wire logic [3:0] tmds_clk_active,
  // Controls toward the analog and EDID logic.
  output logic            signal_loss_detect_enable,
  output logic      [1:0] signal_loss_threshold,
  output logic            autosquelch_enable,
  output logic            replicator_bypass,
  output logic            edid_write_allow
);

  // Reset release through two flip-flops.
  logic       rst_meta_r;
  logic       rst_n_sync;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_r <= 1'b0;
      rst_n_sync <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_sync <= rst_meta_r;
    end
  end

  // Stored registers.
  logic [7:0] pulse_width_r,  pulse_width_nxt;
  logic [7:0] hp_override_r,  hp_override_nxt;
  logic [7:0] loss_ctrl_r,    loss_ctrl_nxt;
  logic [7:0] repl_mode_r,    repl_mode_nxt;
  logic [7:0] write_key_r,    write_key_nxt;
  logic [7:0] rdata_r,        rdata_nxt;
  logic       rvalid_r,       rvalid_nxt;

  // Loss status and synchroniser stages.
  logic [3:0] act_s1_r, act_s2_r, act_s3_r;
  logic [3:0] act_ok_r,       act_ok_nxt;
  logic [3:0] loss_flags_r,   loss_flags_nxt;

  // Hot plug pulse generator.
  swhp_hp_state_t    hp_state_r, hp_state_nxt;
  logic [STEP_W-1:0] step_cnt_r, step_cnt_nxt;
  logic [7:0]        pulse_cnt_r, pulse_cnt_nxt;
  logic [3:0]        pulse_lane_r, pulse_lane_nxt;
  logic [3:0]        oe_n_r, oe_n_nxt;

  logic manual_sel;
  logic [3:0] force_mask;
  logic step_end;

  assign manual_sel = hp_override_r[`SWHP_BIT_MANUAL_SEL];
  assign force_mask = hp_override_r[3:0];
  assign step_end   = (step_cnt_r == STEP_W'(STEP_CYCLES - 1));

  // Register writes and read answers.
  always_comb begin
    pulse_width_nxt = pulse_width_r;
    hp_override_nxt = hp_override_r;
    loss_ctrl_nxt   = loss_ctrl_r;
    repl_mode_nxt   = repl_mode_r;
    write_key_nxt   = write_key_r;
    rdata_nxt       = rdata_r;
    rvalid_nxt      = 1'b0;
    if (reg_wr) begin
      unique case (reg_addr)
        `SWHP_OFS_PULSE_WIDTH: pulse_width_nxt = reg_wdata;
        // Unused upper bits are kept at zero.
        `SWHP_OFS_HP_OVERRIDE: hp_override_nxt = {3'b000, reg_wdata[4:0]};
        `SWHP_OFS_LOSS_CTRL:   loss_ctrl_nxt = {2'b00, reg_wdata[5:4],
                                                1'b0, reg_wdata[2],
                                                1'b0, reg_wdata[0]};
        `SWHP_OFS_REPL_MODE:   repl_mode_nxt = {7'h00, reg_wdata[0]};
        `SWHP_OFS_WRITE_KEY:   write_key_nxt = reg_wdata;
        default: ;
      endcase
    end
    if (reg_rd) begin
      rvalid_nxt = 1'b1;
      unique case (reg_addr)
        `SWHP_OFS_PULSE_WIDTH:  rdata_nxt = pulse_width_r;
        `SWHP_OFS_HP_OVERRIDE:  rdata_nxt = hp_override_r;
        `SWHP_OFS_LOSS_CTRL:    rdata_nxt = loss_ctrl_r;
        `SWHP_OFS_LOSS_STATUS:  rdata_nxt = {4'h0, loss_flags_r};
        `SWHP_OFS_SILICON_STEP: rdata_nxt = SILICON_STEP;
        `SWHP_OFS_PART_CODE:    rdata_nxt = PART_CODE;
        // Write-only and unmapped offsets read as zero.
        default:                rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      pulse_width_r <= `SWHP_RST_PULSE_WIDTH;
      hp_override_r <= `SWHP_RST_HP_OVERRIDE;
      loss_ctrl_r   <= `SWHP_RST_LOSS_CTRL;
      repl_mode_r   <= `SWHP_RST_REPL_MODE;
      write_key_r   <= `SWHP_RST_WRITE_KEY;
      rdata_r       <= `SWHP_RST_READ_DATA;
      rvalid_r      <= 1'b0;
    end else begin
      pulse_width_r <= pulse_width_nxt;
      hp_override_r <= hp_override_nxt;
      loss_ctrl_r   <= loss_ctrl_nxt;
      repl_mode_r   <= repl_mode_nxt;
      write_key_r   <= write_key_nxt;
      rdata_r       <= rdata_nxt;
      rvalid_r      <= rvalid_nxt;
    end
  end

  // Three-stage synchroniser for the activity levels. The stages start at
  // active, as the filter does, so no false loss shows after reset.
  always_ff @(posedge mclk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      act_s1_r <= 4'hf;
      act_s2_r <= 4'hf;
      act_s3_r <= 4'hf;
    end else begin
      act_s1_r <= tmds_clk_active;
      act_s2_r <= act_s1_r;
      act_s3_r <= act_s2_r;
    end
  end

  // Filtered activity and loss flags; a bit changes once stages agree.
  always_comb begin
    act_ok_nxt = act_ok_r;
    for (int i = 0; i < 4; i++) begin
      if (act_s2_r[i] == act_s3_r[i]) begin
        act_ok_nxt[i] = act_s3_r[i];
      end
    end
    if (loss_ctrl_r[`SWHP_BIT_LOSS_EN]) begin
      loss_flags_nxt = ~act_ok_r;
    end else begin
      loss_flags_nxt = 4'h0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      act_ok_r     <= 4'hf;
      loss_flags_r <= 4'h0;
    end else begin
      act_ok_r     <= act_ok_nxt;
      loss_flags_r <= loss_flags_nxt;
    end
  end

  // Automatic pulse: one input held low for width times the step.
  always_comb begin
    hp_state_nxt   = hp_state_r;
    step_cnt_nxt   = step_cnt_r;
    pulse_cnt_nxt  = pulse_cnt_r;
    pulse_lane_nxt = pulse_lane_r;
    unique case (hp_state_r)
      SWHP_HP_IDLE: begin
        if (chan_switch && !manual_sel && pulse_width_r != 8'h00) begin
          hp_state_nxt   = SWHP_HP_LOW;
          step_cnt_nxt   = '0;
          pulse_cnt_nxt  = pulse_width_r;
          pulse_lane_nxt = 4'b0001 << chan_sel;
        end
      end
      SWHP_HP_LOW: begin
        if (manual_sel) begin
          // Manual mode takes over and drops any running pulse.
          hp_state_nxt   = SWHP_HP_IDLE;
          pulse_lane_nxt = 4'h0;
        end else if (chan_switch) begin
          // A new switch restarts the pulse on the new input, or ends it when the width is zero.
          step_cnt_nxt   = '0;
          pulse_cnt_nxt  = pulse_width_r;
          pulse_lane_nxt = 4'b0001 << chan_sel;
          if (pulse_width_r == 8'h00) begin
            hp_state_nxt   = SWHP_HP_IDLE;
            pulse_lane_nxt = 4'h0;
          end
        end else if (step_end) begin
          step_cnt_nxt  = '0;
          pulse_cnt_nxt = pulse_cnt_r - 8'h01;
          if (pulse_cnt_r == 8'h01) begin
            hp_state_nxt   = SWHP_HP_IDLE;
            pulse_lane_nxt = 4'h0;
          end
        end else begin
          step_cnt_nxt = step_cnt_r + STEP_W'(1);
        end
      end
    endcase
    if (manual_sel) begin
      oe_n_nxt = ~force_mask;
    end else begin
      oe_n_nxt = ~pulse_lane_nxt;
    end
  end

  always_ff @(posedge mclk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      hp_state_r   <= SWHP_HP_IDLE;
      step_cnt_r   <= '0;
      pulse_cnt_r  <= 8'h00;
      pulse_lane_r <= 4'h0;
      oe_n_r       <= 4'hf;
    end else begin
      hp_state_r   <= hp_state_nxt;
      step_cnt_r   <= step_cnt_nxt;
      pulse_cnt_r  <= pulse_cnt_nxt;
      pulse_lane_r <= pulse_lane_nxt;
      oe_n_r       <= oe_n_nxt;
    end
  end

  // Control outputs, registered.
  logic       loss_en_r, squelch_r, bypass_r, wr_allow_r;
  logic [1:0] thr_r;

  always_ff @(posedge mclk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      loss_en_r  <= 1'b0;
      squelch_r  <= 1'b0;
      thr_r      <= 2'b00;
      bypass_r   <= 1'b0;
      wr_allow_r <= 1'b0;
    end else begin
      loss_en_r  <= loss_ctrl_nxt[`SWHP_BIT_LOSS_EN];
      thr_r      <= loss_ctrl_nxt[`SWHP_BIT_THR_HI:`SWHP_BIT_THR_LO];
      squelch_r  <= loss_ctrl_nxt[`SWHP_BIT_SQUELCH_EN];
      bypass_r   <= repl_mode_nxt[`SWHP_BIT_REPL_BYPASS];
      wr_allow_r <= (write_key_nxt == `SWHP_UNLOCK_KEY);
    end
  end

  // Port assignments; the pad drives low only when enabled.
  assign hot_plug_out              = 4'h0;
  assign hot_plug_oe_n             = oe_n_r;
  assign reg_rdata                 = rdata_r;
  assign reg_rvalid                = rvalid_r;
  assign signal_loss_detect_enable = loss_en_r;
  assign signal_loss_threshold     = thr_r;
  assign autosquelch_enable        = squelch_r;
  assign replicator_bypass         = bypass_r;
  assign edid_write_allow          = wr_allow_r;

endmodule

// ### swhp_host.sv
/*
  Host model on the register port: single-byte writes and reads.
  Assumes the bank samples strobes on the rising edge of mclk.
*/
`timescale 1ns/10ps
module swhp_host (
  // Clock.
  input  wire logic       mclk,
  // Register port toward the bank.
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  // Port is idle at time zero.
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;  // Released lines do not keep the last value.
    reg_wdata <= ~d;
  endtask

  // One read; the answer is awaited for a bounded time only.
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic ok);
    ok = 1'b0;
    d = 8'h00;
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    // The answer is looked at mid-cycle, where it has settled.
    for (int i = 0; i < 4 && !ok; i++) begin
      @(negedge mclk);
      if (reg_rvalid === 1'b1) begin
        ok = 1'b1;
        d = reg_rdata;
      end
    end
    // Return on a rising edge so that callers drive on that edge.
    @(posedge mclk);
  endtask
endmodule

// ### swhp_regs_asserts.sv
/*
  Port checker for the register bank.
  Assumes it is bound onto swhp_regs and sees only its ports.
*/
`timescale 1ns/10ps
module swhp_regs_chk #(
  // Identification values are arbitrary.
  parameter logic [7:0] SILICON_STEP = 8'h5a,
  parameter logic [7:0] PART_CODE    = 8'h11
) (
  input wire logic       mclk,
  input wire logic       arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_rvalid,
  input wire logic [3:0] hot_plug_oe_n,
  input wire logic       signal_loss_detect_enable,
  input wire logic [1:0] signal_loss_threshold,
  input wire logic       autosquelch_enable,
  input wire logic       replicator_bypass,
  input wire logic       edid_write_allow
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  // A write to one offset followed by an idle cycle.
  sequence s_wr(logic [7:0] a);
    reg_wr && reg_addr == a ##1 !reg_wr;
  endsequence

  chk_manual_mask: assert property (
    reg_wr && reg_addr == 8'h06 && reg_wdata[4] ##1 !reg_wr |=>
    hot_plug_oe_n == ~$past(reg_wdata[3:0], 2)) else $error("mask pins");
  chk_mask_release: assert property (
    reg_wr && reg_addr == 8'h06 && reg_wdata[4:0] == 5'h10 ##1 !reg_wr
    |=> hot_plug_oe_n == 4'hf) else $error("pins not released");
  chk_detect_en: assert property (s_wr(8'h07) |=>
    signal_loss_detect_enable == $past(reg_wdata[0], 2)) else $error("en");
  chk_loss_thr: assert property (s_wr(8'h07) |=>
    signal_loss_threshold == $past(reg_wdata[5:4], 2)) else $error("thr");
  chk_squelch_bit: assert property (s_wr(8'h07) |=>
    autosquelch_enable == $past(reg_wdata[2], 2)) else $error("squelch");
  chk_bypass_bit: assert property (s_wr(8'h0e) |=>
    replicator_bypass == $past(reg_wdata[0], 2)) else $error("bypass");
  chk_key_gate: assert property (s_wr(8'h0f) |=>
    edid_write_allow == ($past(reg_wdata, 2) == 8'h96)) else $error("key");
  chk_part_read: assert property (reg_rd && reg_addr == 8'hff |=>
    reg_rvalid && reg_rdata == PART_CODE) else $error("part code");
  chk_step_read: assert property (reg_rd && reg_addr == 8'hfe |=>
    reg_rvalid && reg_rdata == SILICON_STEP) else $error("revision");

  cover property (reg_wr && reg_addr == 8'h0f && reg_wdata == 8'h96);
  cover property (hot_plug_oe_n == 4'h0);
  cover property (reg_rvalid && reg_rdata == 8'h0f);
endmodule

bind swhp_regs swhp_regs_chk #(
  .SILICON_STEP (SILICON_STEP),
  .PART_CODE    (PART_CODE)
) i_chk (.mclk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .reg_rvalid, .hot_plug_oe_n, .signal_loss_detect_enable,
  .signal_loss_threshold, .autosquelch_enable, .replicator_bypass,
  .edid_write_allow);

// ### switch_hotplug_los_edid_regs_tb_top.sv
/*
  Self-checking bench for the register bank with a host model.
  Assumes a 125 MHz mclk and a shortened hot plug step.
*/
`timescale 1ns/10ps
module switch_hotplug_los_edid_regs_tb_top;
  localparam int         STEP = 4;
  localparam logic [7:0] SI_STEP = 8'h5a;  // Arbitrary value.
  localparam logic [7:0] PART    = 8'h11;  // Arbitrary value.
  logic       mclk = 1'b0;
  logic       arst_n, reg_wr, reg_rd, reg_rvalid, chan_switch;
  logic       signal_loss_detect_enable, autosquelch_enable;
  logic       replicator_bypass, edid_write_allow;
  logic [1:0] chan_sel, signal_loss_threshold;
  logic [3:0] hot_plug_out, hot_plug_oe_n, tmds_clk_active;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  int         n_fail, n_checks;

  swhp_regs #(
    .STEP_CYCLES  (STEP),
    .SILICON_STEP (SI_STEP),
    .PART_CODE    (PART)
  ) i_dut (
    .mclk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .reg_rvalid, .chan_switch, .chan_sel, .hot_plug_out, .hot_plug_oe_n,
    .tmds_clk_active, .signal_loss_detect_enable, .signal_loss_threshold,
    .autosquelch_enable, .replicator_bypass, .edid_write_allow);
  swhp_host i_host (.mclk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .reg_rvalid);

  // Clock generator.
  always #4 mclk = ~mclk;

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    i_host.rd(a, d, ok);
    chk({7'h0, ok}, 8'h01);
    chk(d, exp);
  endtask

  task automatic t_defaults;
    logic [7:0] ofs [8] = '{8'h05, 8'h06, 8'h07, 8'h0e, 8'h0f, 8'h10,
                            8'hfe, 8'hff};
    logic [7:0] exv [8] = '{8'h05, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                            SI_STEP, PART};
    logic [7:0] ro  [4] = '{8'h10, 8'hfe, 8'hff, 8'h20};
    logic [7:0] rox [4] = '{8'h00, SI_STEP, PART, 8'h00};
    foreach (ofs[i]) rdc(ofs[i], exv[i]);
    chk({4'h0, hot_plug_oe_n}, 8'h0f);
    chk({2'h0, edid_write_allow, replicator_bypass, autosquelch_enable,
         signal_loss_threshold, signal_loss_detect_enable}, 8'h00);
    foreach (ro[i]) i_host.wr(ro[i], 8'hff);
    foreach (ro[i]) rdc(ro[i], rox[i]);
  endtask

  task automatic t_manual;
    logic [3:0] m [6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'hf};
    foreach (m[i]) begin
      i_host.wr(8'h06, {4'h1, m[i]});
      tick(2);
      @(negedge mclk);
      chk({4'h0, hot_plug_oe_n}, {4'h0, ~m[i]});
      chk({4'h0, hot_plug_out}, 8'h00);
    end
    rdc(8'h06, 8'h1f);
    i_host.wr(8'h06, 8'he0);
    rdc(8'h06, 8'h00);
  endtask

  task automatic t_auto;
    logic [7:0] wd [3] = '{8'h00, 8'h02, 8'h03};
    int         n;
    foreach (wd[i]) begin
      i_host.wr(8'h05, wd[i]);
      @(posedge mclk);
      chan_switch <= 1'b1;
      chan_sel <= 2'(i + 1);
      @(posedge mclk);
      chan_switch <= 1'b0;
      n = 0;
      // The pin is looked at mid-cycle, where it has settled.
      repeat (40) begin
        @(negedge mclk);
        if (hot_plug_oe_n === ~(4'h1 << (i + 1))) n++;
      end
      chk(8'(n), 8'(wd[i] * STEP));
      chk({4'h0, hot_plug_oe_n}, 8'h0f);
    end
  endtask

  task automatic t_loss;
    logic [3:0] p [4] = '{4'h0, 4'h1, 4'h8, 4'hf};
    for (int t = 0; t < 4; t++) begin
      i_host.wr(8'h07, 8'(t * 16 + 5));
      tick(2);
      @(negedge mclk);
      chk({4'h0, signal_loss_threshold, autosquelch_enable,
           signal_loss_detect_enable}, 8'(t * 4 + 3));
    end
    i_host.wr(8'h07, 8'hff);
    rdc(8'h07, 8'h35);
    i_host.wr(8'h07, 8'h01);
    tick(2);
    @(negedge mclk);
    chk({7'h0, autosquelch_enable}, 8'h00);
    foreach (p[i]) begin
      @(posedge mclk);
      tmds_clk_active <= ~p[i];
      tick(8);
      rdc(8'h10, {4'h0, p[i]});
    end
    i_host.wr(8'h07, 8'h00);
    rdc(8'h10, 8'h00);
  endtask

  task automatic t_edid;
    logic [7:0] ad [6] = '{8'h0e, 8'h0e, 8'h0f, 8'h0f, 8'h0f, 8'h0f};
    logic [7:0] dv [6] = '{8'h01, 8'h00, 8'h96, 8'h95, 8'h96, 8'h00};
    logic [1:0] ex [6] = '{2'h1, 2'h0, 2'h2, 2'h0, 2'h2, 2'h0};
    foreach (ad[i]) begin
      i_host.wr(ad[i], dv[i]);
      tick(2);
      @(negedge mclk);
      chk(8'(replicator_bypass), 8'(ex[i][0]));
      chk(8'(edid_write_allow), 8'(ex[i][1]));
    end
    i_host.wr(8'h0f, 8'h96);
    rdc(8'h0f, 8'h00);
  endtask

  task automatic test_done;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Main sequence: reset, then each scenario in turn.
  initial begin
    arst_n = 1'b0;
    chan_switch = 1'b0;
    chan_sel = 2'h0;
    tmds_clk_active = 4'hf;
    tick(16);
    arst_n <= 1'b1;
    tick(3);
    t_defaults;
    t_manual;
    t_auto;
    t_loss;
    t_edid;
    test_done;
  end

  // Watchdog so that a hang still ends with a verdict.
  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    test_done;
  end
endmodule
